/* File: bench/epfc_mem_model.sv */
/*
 * Model of the external program memory with its address latch.
 * Assumes both strobes come from the fetch control block on i_mclk.
 */
`timescale 1ns/100ps

module epfc_mem_model (
    input  wire logic        i_mclk,                   // Oscillator clock.
    input  wire logic        i_resetn,                 // Asynchronous reset, active low.
    input  wire logic        i_program_store_strobe_n, // Read strobe, active low.
    input  wire logic        i_addr_latch_strobe,      // Address latch strobe.
    output logic      [15:0] o_strobe_count,           // Read strobe assertions seen.
    output logic      [15:0] o_latch_count             // Address latch pulses seen.
);
    logic strobe_n_reg;
    logic latch_reg;

    // Each falling read strobe is one code byte read; each latch pulse one address.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            strobe_n_reg   <= 1'b1;
            latch_reg      <= 1'b0;
            o_strobe_count <= 16'h0000;
            o_latch_count  <= 16'h0000;
        end else begin
            strobe_n_reg <= i_program_store_strobe_n;
            latch_reg    <= i_addr_latch_strobe;
            if (strobe_n_reg && !i_program_store_strobe_n) begin
                o_strobe_count <= o_strobe_count + 16'h0001;
            end
            if (!latch_reg && i_addr_latch_strobe) begin
                o_latch_count <= o_latch_count + 16'h0001;
            end
        end
    end
endmodule

/* File: bench/testbench.sv */
/*
 * Self-checking testbench of the program fetch control block.
 * Assumes the memory model counts the strobes; inputs change at the falling edge.
 */
`timescale 1ns/100ps

module testbench;
    logic        i_mclk;
    logic        i_resetn;
    logic        i_external_access_select_n;
    logic        i_reset_pin;
    logic [15:0] i_pc;
    logic        i_data_access;
    logic        i_idle;
    logic        i_ram_we;
    logic        o_program_store_strobe_n;
    logic        o_addr_latch_strobe;
    logic        o_fetch_external;
    logic        o_ram_we;
    logic        o_internal_reset;
    logic        o_cycle_start;
    logic [15:0] strobe_cnt;
    logic [15:0] latch_cnt;
    int          num_errors;
    int          num_checks;

    epfc_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_external_access_select_n(i_external_access_select_n), .i_reset_pin(i_reset_pin),
        .i_pc(i_pc), .i_data_access(i_data_access), .i_idle(i_idle), .i_ram_we(i_ram_we),
        .o_program_store_strobe_n(o_program_store_strobe_n), .o_addr_latch_strobe(o_addr_latch_strobe),
        .o_fetch_external(o_fetch_external), .o_ram_we(o_ram_we),
        .o_internal_reset(o_internal_reset), .o_cycle_start(o_cycle_start));

    epfc_mem_model mem (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_program_store_strobe_n(o_program_store_strobe_n), .i_addr_latch_strobe(o_addr_latch_strobe),
        .o_strobe_count(strobe_cnt), .o_latch_count(latch_cnt));

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wait_cs;
        int n;
        n = 0;
        @(negedge i_mclk);
        while (o_cycle_start !== 1'b1 && n < 40) begin
            @(negedge i_mclk);
            n++;
        end
        chk(16'(o_cycle_start), 16'h1, "cycle start missing");
    endtask

    task automatic win(input int n, output logic [15:0] s, output logic [15:0] a);
        logic [15:0] s0;
        logic [15:0] a0;
        wait_cs;
        s0 = strobe_cnt;
        a0 = latch_cnt;
        repeat (n) wait_cs;
        s = strobe_cnt - s0;
        a = latch_cnt - a0;
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_cycle;
        int n;
        wait_cs;
        @(negedge i_mclk);
        n = 1;
        while (o_cycle_start !== 1'b1 && n < 30) begin
            @(negedge i_mclk);
            n++;
        end
        chk(16'(n), 16'h000C, "machine cycle length");
    endtask

    task automatic t_ext_fetch;
        logic [15:0] s;
        logic [15:0] a;
        i_external_access_select_n = 1'b0;
        i_pc = 16'h0FFF;
        win(3, s, a);
        chk(s, 16'h0006, "strobes in three external cycles");
        chk(a, 16'h0006, "latch pulses in three cycles");
        chk(16'(o_fetch_external), 16'h1, "low select not external");
    endtask

    // The flag is sampled at the end of a cycle and governs the next one.
    task automatic t_data(input int n, input logic [15:0] exp_s, input logic [15:0] exp_a);
        logic [15:0] s0;
        logic [15:0] a0;
        i_pc = 16'h0000;
        wait_cs;
        i_data_access = 1'b1;
        wait_cs;
        s0 = strobe_cnt;
        a0 = latch_cnt;
        repeat (n - 1) wait_cs;
        i_data_access = 1'b0;
        repeat (4 - n) wait_cs;
        chk(strobe_cnt - s0, exp_s, "strobes around data access");
        chk(latch_cnt - a0, exp_a, "latch pulses around data access");
    endtask

    task automatic t_internal;
        logic [15:0] s;
        logic [15:0] a;
        i_external_access_select_n = 1'b1;
        i_pc = 16'h0FFF;
        wait_cs;
        win(3, s, a);
        chk(s, 16'h0000, "strobe on internal fetch");
        chk(16'(o_fetch_external), 16'h0, "top internal address sent out");
        i_pc = 16'h1000;
        wait_cs;
        win(2, s, a);
        chk(s, 16'h0004, "strobes above internal range");
        chk(16'(o_fetch_external), 16'h1, "address above range kept inside");
    endtask

    task automatic t_idle_reset;
        int n;
        i_ram_we = 1'b1;
        repeat (2) @(negedge i_mclk);
        chk(16'(o_ram_we), 16'h1, "ram write lost");
        // The CPU side enters idle, never power-down, and issues no port or external write after it.
        i_idle = 1'b1;
        i_reset_pin = 1'b1;
        repeat (6) @(negedge i_mclk);
        chk(16'(o_ram_we), 16'h0, "ram write passed during idle exit");
        n = 6;
        while (o_internal_reset !== 1'b1 && n < 60) begin
            @(negedge i_mclk);
            n++;
        end
        chk(16'(n >= 12 && n <= 48), 16'h1, "internal reset delay");
        i_reset_pin = 1'b0;
        i_idle = 1'b0;
        n = 0;
        while (o_internal_reset !== 1'b0 && n < 20) begin
            @(negedge i_mclk);
            n++;
        end
        chk(16'(o_internal_reset), 16'h0, "internal reset stuck");
        repeat (2) @(negedge i_mclk);
        chk(16'(o_ram_we), 16'h1, "ram write still blocked");
        i_ram_we = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        num_checks = 0;
        i_resetn = 1'b0;
        i_external_access_select_n = 1'b0;
        i_reset_pin = 1'b0;
        i_pc = 16'h0000;
        i_data_access = 1'b0;
        i_idle = 1'b0;
        i_ram_we = 1'b0;
        repeat (12) @(negedge i_mclk);
        i_resetn = 1'b1;
        t_cycle;
        t_ext_fetch;
        t_data(1, 16'h0004, 16'h0005);
        t_data(2, 16'h0002, 16'h0004);
        t_internal;
        t_idle_reset;
        print_verdict;
    end

    initial begin
        #(3000 * 100);
        num_errors++;
        print_verdict;
    end
endmodule

/* File: rtl/epfc_map.svh */
/*
 * Constants of the program fetch control block: machine cycle layout,
 * strobe skips, address limits and reset timing.
 * Assumes it is included by bare name from the top-level design file only.
 */
`ifndef EPFC_MAP_SVH
`define EPFC_MAP_SVH

// Oscillator period in ns and derived machine cycle length.
`define EPFC_OSC_PERIOD_NS     100
`define EPFC_PHASES_PER_STATE  2
`define EPFC_STATES_PER_CYCLE  6
`define EPFC_CLKS_PER_CYCLE    (`EPFC_PHASES_PER_STATE * `EPFC_STATES_PER_CYCLE)

// Highest code address held on chip.
`define EPFC_INT_CODE_TOP      16'h0FFF

// Machine cycles the reset pin must stand high before the internal reset.
`define EPFC_RESET_CYCLES      2'h2

// Program store strobe pulses dropped per external data access.
`define EPFC_STROBE_SKIPS      2'h2

`endif

/* File: rtl/epfc_pkg.sv */
/*
 * Types of the program fetch control block.
 * Assumes epfc_map.svh is on the include path.
 */
package epfc_pkg;

    // States of one machine cycle, each two oscillator phases long.
    typedef enum logic [2:0] {
        ST_S1,
        ST_S2,
        ST_S3,
        ST_S4,
        ST_S5,
        ST_S6
    } epfc_state_t;

endpackage

/* File: rtl/epfc_sync.sv */
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous levels; a pulse shorter than one
 * clock may be missed.
 */
`timescale 1ns/100ps

module epfc_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_mclk,     // Oscillator clock.
    input  wire logic             i_resetn,   // Asynchronous reset, active low.
    input  wire logic [WIDTH-1:0] i_async,    // Pin levels.
    output logic      [WIDTH-1:0] o_sync      // Levels after two flops.
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;

    initial begin
        if (WIDTH < 1) begin
            $error("epfc_sync: WIDTH must be at least 1");
        end
    end

    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= meta_next;
            o_sync   <= sync_next;
        end
    end

endmodule

/* File: rtl/epfc_top.sv */
/*
 * Program fetch control: machine cycle timing, program store strobe,
 * address latch strobe, internal/external fetch select, reset pin
 * qualification and RAM write blocking on an idle exit by reset.
 * Assumes i_mclk is the oscillator, CPU-side inputs are on i_mclk, and
 * the select and reset pins are asynchronous.
 */
//
// Functional notes
// - Executing from external code memory, the program store strobe pulses twice per machine cycle.
// - Each external data access drops two consecutive program store strobe pulses.
// - Fetches from on-chip code memory leave the program store strobe inactive.
// - A low external access select pin sends every code fetch, from address 0000H up, outside.
// - With the select pin high, fetches stay internal unless the program counter is above 0FFFH.
// - Internal phases come from a toggle stage halving the oscillator, so its duty cycle is irrelevant.
// - After idle is ended by reset, execution may go on for up to two machine cycles before reset takes over.
// - In that interval writes to on-chip RAM are blocked while port accesses pass.
// - The address latch strobe runs at one sixth of the oscillator and drops one pulse per data access.
// - The reset pin must stand high for two machine cycles for a reset to complete.
`timescale 1ns/100ps
`include "epfc_map.svh"

module epfc_top (
    input  wire logic        i_mclk,                      // Oscillator, 10 MHz.
    input  wire logic        i_resetn,                    // Asynchronous reset, active low.
    input  wire logic        i_external_access_select_n,  // Select pin, low forces external fetch.
    input  wire logic        i_reset_pin,                 // Device reset pin, active high.
    input  wire logic [15:0] i_pc,                        // Program counter of the CPU.
    input  wire logic        i_data_access,               // Next machine cycle is an external data access.
    input  wire logic        i_idle,                      // CPU is in idle mode.
    input  wire logic        i_ram_we,                    // CPU write request to on-chip RAM.
    output logic             o_program_store_strobe_n,    // Program store read strobe, active low.
    output logic             o_addr_latch_strobe,         // Address latch strobe, active high.
    output logic             o_fetch_external,            // Code fetch goes to external memory.
    output logic             o_ram_we,                    // Gated on-chip RAM write.
    output logic             o_internal_reset,            // Internal reset sequence active.
    output logic             o_cycle_start                // One-clock pulse at each machine cycle start.
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    logic [1:0] pins_sync;
    logic       sel_n_s;
    logic       rst_pin_s;

    epfc_sync #(
        .WIDTH (2)
    ) u_sync (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_async  ({i_reset_pin, i_external_access_select_n}),
        .o_sync   (pins_sync)
    );

    assign sel_n_s   = pins_sync[0];
    assign rst_pin_s = pins_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Phase toggle and state sequencing.

    logic                 ph_reg;
    logic                 ph_next;
    epfc_pkg::epfc_state_t st_reg;
    epfc_pkg::epfc_state_t st_next;
    logic                 cyc_end;

    assign cyc_end = (st_reg == epfc_pkg::ST_S6) && ph_reg;

    always_comb begin
        ph_next = ~ph_reg;
        st_next = st_reg;
        if (ph_reg) begin
            unique case (st_reg)
                epfc_pkg::ST_S1: st_next = epfc_pkg::ST_S2;
                epfc_pkg::ST_S2: st_next = epfc_pkg::ST_S3;
                epfc_pkg::ST_S3: st_next = epfc_pkg::ST_S4;
                epfc_pkg::ST_S4: st_next = epfc_pkg::ST_S5;
                epfc_pkg::ST_S5: st_next = epfc_pkg::ST_S6;
                epfc_pkg::ST_S6: st_next = epfc_pkg::ST_S1;
                default:         st_next = epfc_pkg::ST_S1;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ph_reg <= 1'b0;
            st_reg <= epfc_pkg::ST_S1;
        end else begin
            ph_reg <= ph_next;
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fetch select, data access cycle, reset qualification, idle exit.

    logic       ext_reg;
    logic       ext_next;
    logic       dx_reg;
    logic       dx_next;
    logic [1:0] rcnt_reg;
    logic [1:0] rcnt_next;
    logic       irst_next;
    logic       irst_reg;
    logic       idle_rst_reg;
    logic       idle_rst_next;

    always_comb begin
        ext_next      = ~sel_n_s | (i_pc > `EPFC_INT_CODE_TOP);
        dx_next       = cyc_end ? i_data_access : dx_reg;
        rcnt_next     = rcnt_reg;
        if (!rst_pin_s) begin
            rcnt_next = 2'h0;
        end else if (cyc_end && rcnt_reg != `EPFC_RESET_CYCLES) begin
            rcnt_next = rcnt_reg + 2'h1;
        end
        irst_next     = rst_pin_s && (rcnt_reg == `EPFC_RESET_CYCLES);
        idle_rst_next = idle_rst_reg;
        if (irst_reg) begin
            idle_rst_next = 1'b0;
        end else if (i_idle && rst_pin_s) begin
            idle_rst_next = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_reg      <= 1'b0;
            dx_reg       <= 1'b0;
            rcnt_reg     <= 2'h0;
            irst_reg     <= 1'b0;
            idle_rst_reg <= 1'b0;
        end else begin
            ext_reg      <= ext_next;
            dx_reg       <= dx_next;
            rcnt_reg     <= rcnt_next;
            irst_reg     <= irst_next;
            idle_rst_reg <= idle_rst_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output strobes.

    logic strobe_next;
    logic ale_next;
    logic ramwe_next;
    logic start_next;
    logic quiet;

    // Idle holds both strobes high; internal reset holds both inactive.
    assign quiet = irst_reg | i_idle;

    always_comb begin
        strobe_next = 1'b1;
        ale_next   = 1'b0;
        if (i_idle && !irst_reg) begin
            ale_next = 1'b1;
        end else if (!quiet) begin
            if (ext_reg && (st_reg == epfc_pkg::ST_S3 || st_reg == epfc_pkg::ST_S6)) begin
                strobe_next = dx_reg;
            end
            if (st_reg == epfc_pkg::ST_S5 || (st_reg == epfc_pkg::ST_S2 && !dx_reg)) begin
                ale_next = 1'b1;
            end
        end
        ramwe_next = i_ram_we & ~idle_rst_reg & ~irst_reg;
        start_next = cyc_end;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_program_store_strobe_n <= 1'b1;
            o_addr_latch_strobe      <= 1'b0;
            o_fetch_external         <= 1'b0;
            o_ram_we                 <= 1'b0;
            o_internal_reset         <= 1'b0;
            o_cycle_start            <= 1'b0;
        end else begin
            o_program_store_strobe_n <= strobe_next;
            o_addr_latch_strobe      <= ale_next;
            o_fetch_external         <= ext_reg;
            o_ram_we                 <= ramwe_next;
            o_internal_reset         <= irst_reg;
            o_cycle_start            <= start_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    // The first edge after reset compares with the reset value, so look one edge later.
    a_phase_toggle: assert property (1'b1 |=> (ph_reg != $past(ph_reg)))
        else $error("phase did not toggle");
    a_cycle_twelve: assert property (o_cycle_start |-> ##12 o_cycle_start)
        else $error("machine cycle not twelve clocks");
    a_strobe_external: assert property ((st_reg == epfc_pkg::ST_S3) && !ph_reg && ext_reg && !dx_reg && !quiet
        |=> !o_program_store_strobe_n [*2])
        else $error("program store strobe missing in external fetch");
    a_strobe_skip: assert property (dx_reg && (st_reg == epfc_pkg::ST_S3 || st_reg == epfc_pkg::ST_S6)
        |=> o_program_store_strobe_n)
        else $error("program store strobe not skipped on data access");
    a_strobe_internal: assert property (!ext_reg |=> o_program_store_strobe_n)
        else $error("program store strobe active on internal fetch");
    a_select_low: assert property (!sel_n_s |=> ##1 o_fetch_external)
        else $error("select low did not force external fetch");
    a_pc_high: assert property (sel_n_s && (i_pc > `EPFC_INT_CODE_TOP) |=> ##1 o_fetch_external)
        else $error("counter above internal top not fetched externally");
    a_ale_rate: assert property ((st_reg == epfc_pkg::ST_S5) && !ph_reg && !quiet |=> o_addr_latch_strobe [*2])
        else $error("address latch strobe missing");
    a_ale_skip: assert property (dx_reg && (st_reg == epfc_pkg::ST_S2) && !quiet |=> !o_addr_latch_strobe)
        else $error("address latch strobe not skipped");
    a_reset_two: assert property (rst_pin_s && (rcnt_reg == `EPFC_RESET_CYCLES) |=> ##1 o_internal_reset)
        else $error("internal reset not entered");
    a_ram_block: assert property (idle_rst_reg |=> !o_ram_we)
        else $error("RAM write passed during idle reset exit");
    a_idle_hold: assert property (i_idle && rst_pin_s && !irst_reg |=> idle_rst_reg)
        else $error("idle exit by reset not noted");

    c_ext_fetch: cover property (!o_program_store_strobe_n ##1 o_program_store_strobe_n);
    c_data_skip: cover property (dx_reg && ext_reg && (st_reg == epfc_pkg::ST_S6));
    c_int_reset: cover property ($rose(o_internal_reset));
    c_idle_exit: cover property (idle_rst_reg && i_ram_we);

endmodule
